// ===== hdl/front_panel_pkg.sv
// holds constants, register offsets, carrier structs and state types for the front-panel indicator logic
// assumes a single 25 MHz system clock and core flags that are already synchronous to it
// Contract
// (R1) the system health lamp is green while the system runs with no detected fault.
// (R2) the system health lamp is yellow on a detected fault and while status is still pending after reset.
// (R3) the system health lamp is dark during reset and while the system has failed.
// (R4) the sync lamp is on only while receive framing is found and the unit is synchronized to the far unit.
// (R5) the composite clock lamp is on only while both receive and transmit clocks are present.
// (R6) the composite receive data lamp is on while the receive data line toggles and off when it sits still.
// (R7) the composite transmit data lamp is on while the transmit data line toggles and off when it sits still.
// (R8) the composite loop lamp is steady on while the local port is in transmit or receive loopback.
// (R9) the composite loop lamp flashes with a one second period while the far port is in loopback.
// (R10) a hot-inserted port card is asked to be reprogrammed from the working copy, without stalling other traffic.
// (R11) a clock or data line counts as idle after a fixed window with no transition, and any transition restarts it.
// (R12) the flash cadence comes from a free-running divider cleared by reset so that all flashing is in phase.
package front_panel_pkg;

	// clock and timing
	localparam int CLK_HZ             = 25_000_000;
	localparam int CLK_KHZ            = CLK_HZ / 1000;
	localparam int CLK_MHZ            = CLK_HZ / 1_000_000;
	localparam int FLASH_PERIOD_MS    = 1000;
	localparam int FLASH_HALF_DEFAULT = (CLK_KHZ * FLASH_PERIOD_MS) / 2;
	localparam int ACT_WINDOW_US      = 10000;
	localparam int ACT_WINDOW_DEFAULT = CLK_MHZ * ACT_WINDOW_US;
	localparam int FLASH_CNT_W        = 24;
	localparam int ACT_CNT_W          = 18;

	// register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_INDICATOR  = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CONTROL    = 8'h0c;

	// port cards and watched composite lines
	localparam int CARDS       = 4;
	localparam int LINES       = 4;
	localparam int LN_TX_DATA  = 0;
	localparam int LN_RX_DATA  = 1;
	localparam int LN_TX_CLK   = 2;
	localparam int LN_RX_CLK   = 3;

	typedef enum logic [3:0] {
		HS_PENDING = 4'h1,
		HS_GOOD    = 4'h2,
		HS_FAULT   = 4'h4,
		HS_DEAD    = 4'h8
	} health_e;

	typedef struct packed {
		logic loop;
		logic tx_data;
		logic rx_data;
		logic clock;
		logic sync;
		logic yellow;
		logic green;
	} led_s;

	typedef struct packed {
		logic card_inserted;
		logic clock_lost;
		logic sync_lost;
		logic fault;
	} irq_s;
	localparam int IRQ_W = $bits(irq_s);

	typedef struct packed {
		logic lamp_test;
	} ctrl_s;
	localparam int CTRL_W = $bits(ctrl_s);

	typedef struct packed {
		logic pending;
		logic fault;
		logic failed;
		logic framing_locked;
		logic local_tx_loop;
		logic local_rx_loop;
		logic remote_loop;
	} core_s;

	typedef struct packed {
		logic rx_clk;
		logic tx_clk;
		logic rx_data;
		logic tx_data;
	} comp_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wr_data;
		logic              wr_en;
		logic              rd_en;
	} reg_req_s;

	typedef struct packed {
		logic                 prev;
		logic                 active;
		logic [ACT_CNT_W-1:0] cnt;
	} act_s;

	typedef struct packed {
		health_e              health;
		led_s                 leds;
		logic [CARDS-1:0]     reprogram;
		logic [FLASH_CNT_W-1:0] flash_cnt;
		logic                 flash_phase;
		logic [IRQ_W-1:0]     irq_status;
		logic [IRQ_W-1:0]     irq_mask;
		ctrl_s                ctrl;
		logic [DATA_W-1:0]    rd_data;
		logic                 irq;
		logic                 prev_locked;
		logic                 prev_clk_ok;
		logic                 prev_fault;
		logic [CARDS-1:0]     prev_present;
	} panel_s;

	localparam panel_s PANEL_RESET = '{health: HS_PENDING, default: '0};
	localparam act_s   ACT_RESET   = '{default: '0};

endpackage : front_panel_pkg

// ===== hdl/line_activity.sv
// holds the transition watcher for one composite clock or data line
// assumes the line is already synchronous to clk
`timescale 1ns/1ps
module line_activity #(
	parameter int WINDOW_CYCLES = front_panel_pkg::ACT_WINDOW_DEFAULT
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic line,
	output logic      active
);
	import front_panel_pkg::*;

	act_s q;
	act_s d;

	// any edge reloads the window, a quiet window clears the flag
	always_comb begin
		d = q;
		d.prev = line;
		if (line != q.prev) begin
			d.cnt    = ACT_CNT_W'(WINDOW_CYCLES - 1); // [R11]
			d.active = 1'b1;
		end else if (q.cnt != '0) begin
			d.cnt = q.cnt - 1'b1;
		end else begin
			d.active = 1'b0; // [R11]
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= ACT_RESET;
		end else begin
			q <= d;
		end
	end

	assign active = q.active;

	// watcher checks
	AST_EDGE_WAKES: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
		(line != q.prev) |=> (active && q.cnt == ACT_CNT_W'(WINDOW_CYCLES - 1)))
		else $error("edge did not restart activity window");
	AST_QUIET_SLEEPS: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
		(q.cnt == '0 && line == q.prev) |=> !active)
		else $error("activity held after quiet window");

endmodule : line_activity

// ===== hdl/front_panel.sv
// holds the processor card front-panel indicator logic with its register port and interrupt
// assumes core flags, composite lines and card presence are synchronous to clk
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
module front_panel #(
	parameter int FLASH_HALF_CYCLES = front_panel_pkg::FLASH_HALF_DEFAULT,
	parameter int ACT_WINDOW_CYCLES = front_panel_pkg::ACT_WINDOW_DEFAULT
) (
	input  wire logic                                 clk,
	input  wire logic                                 rst_b,
	input  wire front_panel_pkg::core_s               core,
	input  wire front_panel_pkg::comp_s               comp,
	input  wire logic [front_panel_pkg::CARDS-1:0]    card_present,
	input  wire logic [front_panel_pkg::CARDS-1:0]    reprogram_done,
	input  wire front_panel_pkg::reg_req_s            bus,
	output front_panel_pkg::led_s                     leds,
	output logic [front_panel_pkg::CARDS-1:0]         reprogram_req,
	output logic                                      irq,
	output logic [front_panel_pkg::DATA_W-1:0]        rd_data
);
	import front_panel_pkg::*;

	panel_s            q;
	panel_s            d;
	logic [LINES-1:0]  lines;
	logic [LINES-1:0]  activity;
	logic              clk_ok;
	logic              lamp;
	irq_s              ev;
	logic [IRQ_W-1:0]  w1c;
	logic [CARDS-1:0]  inserted;

	// address match shared by write and read decode
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	// rising edge of a level against its last sample
	function automatic logic rising(input logic cur, input logic prev);
		rising = cur & ~prev;
	endfunction : rising

	// watched composite lines in index order
	assign lines = {comp.rx_clk, comp.tx_clk, comp.rx_data, comp.tx_data};

	// one transition watcher per line
	for (genvar i = 0; i < LINES; i++) begin : g_act
		line_activity #(
			.WINDOW_CYCLES (ACT_WINDOW_CYCLES)
		) u_act (
			.clk    (clk),
			.rst_b  (rst_b),
			.line   (lines[i]),
			.active (activity[i])
		);
	end

	// next state of the whole panel
	always_comb begin
		d        = q;
		lamp     = q.ctrl.lamp_test;
		clk_ok   = activity[LN_RX_CLK] & activity[LN_TX_CLK]; // [R5]
		inserted = '0;
		w1c      = '0;
		ev       = '0;

		// health state, failure outranks fault outranks pending
		if (core.failed) begin
			d.health = HS_DEAD; // [R3]
		end else if (core.fault) begin
			d.health = HS_FAULT; // [R2]
		end else if (core.pending) begin
			d.health = HS_PENDING; // [R2]
		end else begin
			d.health = HS_GOOD; // [R1]
		end

		// free-running flash divider, half period per phase
		if (q.flash_cnt == FLASH_CNT_W'(FLASH_HALF_CYCLES - 1)) begin
			d.flash_cnt   = '0; // [R12]
			d.flash_phase = ~q.flash_phase; // [R12]
		end else begin
			d.flash_cnt = q.flash_cnt + 1'b1;
		end

		// bicolor health lamp
		case (d.health)
			HS_GOOD: begin
				d.leds.green  = 1'b1; // [R1]
				d.leds.yellow = 1'b0;
			end
			HS_PENDING, HS_FAULT: begin
				d.leds.green  = 1'b0;
				d.leds.yellow = 1'b1; // [R2]
			end
			default: begin
				d.leds.green  = 1'b0; // [R3]
				d.leds.yellow = 1'b0;
			end
		endcase

		// link lamps
		d.leds.sync    = core.framing_locked; // [R4]
		d.leds.clock   = clk_ok; // [R5]
		d.leds.rx_data = activity[LN_RX_DATA]; // [R6]
		d.leds.tx_data = activity[LN_TX_DATA]; // [R7]

		// local loop is steady and wins over the flashing remote indication
		if (core.local_tx_loop || core.local_rx_loop) begin
			d.leds.loop = 1'b1; // [R8]
		end else if (core.remote_loop) begin
			d.leds.loop = d.flash_phase; // [R9]
		end else begin
			d.leds.loop = 1'b0;
		end

		// lamp test lights every lamp
		if (lamp) begin
			d.leds = '1;
		end

		// hot-insert reprogram request, insertion wins over a done in the same cycle
		for (int i = 0; i < CARDS; i++) begin
			inserted[i] = rising(card_present[i], q.prev_present[i]);
			if (inserted[i]) begin
				d.reprogram[i] = 1'b1; // [R10]
			end else if (reprogram_done[i] || !card_present[i]) begin
				d.reprogram[i] = 1'b0;
			end
		end

		// event detection
		ev.fault         = rising(core.fault, q.prev_fault);
		ev.sync_lost     = rising(q.prev_locked, core.framing_locked);
		ev.clock_lost    = rising(q.prev_clk_ok, clk_ok);
		ev.card_inserted = |inserted;
		d.prev_fault     = core.fault;
		d.prev_locked    = core.framing_locked;
		d.prev_clk_ok    = clk_ok;
		d.prev_present   = card_present;

		// register writes
		if (bus.wr_en) begin
			if (hit(bus.addr, OFF_IRQ_STATUS)) begin
				w1c = bus.wr_data[IRQ_W-1:0];
			end else if (hit(bus.addr, OFF_IRQ_MASK)) begin
				d.irq_mask = bus.wr_data[IRQ_W-1:0];
			end else if (hit(bus.addr, OFF_CONTROL)) begin
				d.ctrl = ctrl_s'(bus.wr_data[CTRL_W-1:0]);
			end
		end

		// sticky status, a new event wins over its clear
		d.irq_status = (q.irq_status & ~w1c) | ev;
		d.irq        = |(d.irq_status & d.irq_mask);

		// read data stand only in the cycle after the strobe
		d.rd_data = '0;
		if (bus.rd_en) begin
			if (hit(bus.addr, OFF_INDICATOR)) begin
				d.rd_data = DATA_W'({q.health, q.reprogram, q.flash_phase, q.leds});
			end else if (hit(bus.addr, OFF_IRQ_STATUS)) begin
				d.rd_data = DATA_W'(q.irq_status);
			end else if (hit(bus.addr, OFF_IRQ_MASK)) begin
				d.rd_data = DATA_W'(q.irq_mask);
			end else if (hit(bus.addr, OFF_CONTROL)) begin
				d.rd_data = DATA_W'(q.ctrl);
			end
		end
	end

	// state register; reset leaves every lamp dark
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= PANEL_RESET; // [R3] [R12]
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign leds          = q.leds;
	assign reprogram_req = q.reprogram;
	assign irq           = q.irq;
	assign rd_data       = q.rd_data;

	// health lamp checks
	AST_GREEN_RUN: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
		(!q.ctrl.lamp_test && !core.failed && !core.fault && !core.pending)
		|=> (leds.green && !leds.yellow))
		else $error("health lamp not green while running clean");
	AST_YELLOW_FAULT: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
		(!q.ctrl.lamp_test && !core.failed && (core.fault || core.pending))
		|=> (leds.yellow && !leds.green))
		else $error("health lamp not yellow on fault or pending");
	AST_DARK_FAILED: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
		(!q.ctrl.lamp_test && core.failed) |=> (!leds.green && !leds.yellow))
		else $error("health lamp lit while failed");
	AST_DARK_RESET: assert property (@(posedge clk) // [R3]
		(!rst_b) |-> (!leds.green && !leds.yellow))
		else $error("health lamp lit in reset");

	// link lamp checks
	AST_SYNC_LAMP: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
		(!q.ctrl.lamp_test) |=> (leds.sync == $past(core.framing_locked)))
		else $error("sync lamp does not follow framing");
	AST_CLOCK_LAMP: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
		(!q.ctrl.lamp_test)
		|=> (leds.clock == $past(activity[LN_RX_CLK] && activity[LN_TX_CLK])))
		else $error("clock lamp not both clocks present");
	AST_RX_LAMP: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
		(!q.ctrl.lamp_test) |=> (leds.rx_data == $past(activity[LN_RX_DATA])))
		else $error("receive data lamp wrong");
	AST_TX_LAMP: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
		(!q.ctrl.lamp_test) |=> (leds.tx_data == $past(activity[LN_TX_DATA])))
		else $error("transmit data lamp wrong");

	// loop lamp and cadence checks
	AST_LOCAL_LOOP: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
		(core.local_tx_loop || core.local_rx_loop) |=> leds.loop)
		else $error("loop lamp not steady in local loopback");
	AST_REMOTE_FLASH: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
		(!q.ctrl.lamp_test && !core.local_tx_loop && !core.local_rx_loop && core.remote_loop)
		|=> (leds.loop == q.flash_phase))
		else $error("loop lamp not flashing with cadence in remote loopback");
	AST_FLASH_STEP: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
		(q.flash_cnt == FLASH_CNT_W'(FLASH_HALF_CYCLES - 1))
		|=> (q.flash_phase != $past(q.flash_phase) && q.flash_cnt == '0))
		else $error("flash phase did not toggle at divider wrap");
	AST_FLASH_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
		(q.flash_cnt != FLASH_CNT_W'(FLASH_HALF_CYCLES - 1)) |=> $stable(q.flash_phase))
		else $error("flash phase moved between wraps");

	// hot-insert check
	AST_REPROGRAM: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
		(|(card_present & ~q.prev_present))
		|=> ((reprogram_req & $past(card_present & ~q.prev_present)) == $past(card_present & ~q.prev_present)))
		else $error("inserted card not flagged for reprogram");
	AST_REPROG_DONE: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
		(|(reprogram_done & ~(card_present & ~q.prev_present)))
		|=> ((reprogram_req & $past(reprogram_done & ~(card_present & ~q.prev_present))) == '0))
		else $error("reprogram request held after done");
	AST_REPROG_GONE: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
		(|(~card_present))
		|=> ((reprogram_req & ~$past(card_present)) == '0))
		else $error("reprogram request held for an empty slot");
	AST_REPROG_RISE: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
		1'b1
		|=> (((reprogram_req & ~$past(reprogram_req)) & ~$past(card_present & ~q.prev_present)) == '0))
		else $error("reprogram request raised without an insertion");

	// interrupt checks, an event wins over its clear
	AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1
		|-> (irq == |(q.irq_status & q.irq_mask)))
		else $error("interrupt level does not match unmasked status");
	AST_FAULT_EVENT: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
		(core.fault && !q.prev_fault)
		|=> q.irq_status[0])
		else $error("fault event not latched");
	AST_SYNC_EVENT: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
		(!core.framing_locked && q.prev_locked)
		|=> q.irq_status[1])
		else $error("sync loss event not latched");
	AST_CLOCK_EVENT: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
		(!clk_ok && q.prev_clk_ok)
		|=> q.irq_status[2])
		else $error("clock loss event not latched");
	AST_CARD_EVENT: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
		(|(card_present & ~q.prev_present))
		|=> q.irq_status[3])
		else $error("card insertion event not latched");
	AST_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
		(!bus.wr_en)
		|=> ((q.irq_status & $past(q.irq_status)) == $past(q.irq_status)))
		else $error("status bit dropped without a clear");
	AST_W1C: assert property (@(posedge clk) disable iff (!rst_b)
		(bus.wr_en && bus.addr == OFF_IRQ_STATUS && ev == '0)
		|=> ((q.irq_status & $past(bus.wr_data[IRQ_W-1:0])) == '0))
		else $error("status bit not cleared by a written one");

	// register port checks
	AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
		(bus.wr_en && bus.addr == OFF_IRQ_MASK)
		|=> (q.irq_mask == $past(bus.wr_data[IRQ_W-1:0])))
		else $error("mask write not taken");
	AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
		(bus.wr_en && bus.addr == OFF_CONTROL)
		|=> (q.ctrl == $past(ctrl_s'(bus.wr_data[CTRL_W-1:0]))))
		else $error("control write not taken");
	AST_RD_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
		(!bus.rd_en)
		|=> (rd_data == '0))
		else $error("read data not zero outside a read");
	AST_RD_MASK: assert property (@(posedge clk) disable iff (!rst_b)
		(bus.rd_en && bus.addr == OFF_IRQ_MASK)
		|=> (rd_data == DATA_W'($past(q.irq_mask))))
		else $error("mask read back wrong");
	AST_RD_STATUS: assert property (@(posedge clk) disable iff (!rst_b)
		(bus.rd_en && bus.addr == OFF_IRQ_STATUS)
		|=> (rd_data == DATA_W'($past(q.irq_status))))
		else $error("status read back wrong");
	AST_RD_CTRL: assert property (@(posedge clk) disable iff (!rst_b)
		(bus.rd_en && bus.addr == OFF_CONTROL)
		|=> (rd_data == DATA_W'($past(q.ctrl))))
		else $error("control read back wrong");
	AST_RD_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_b)
		(bus.rd_en && bus.addr != OFF_INDICATOR && bus.addr != OFF_IRQ_STATUS
			&& bus.addr != OFF_IRQ_MASK && bus.addr != OFF_CONTROL)
		|=> (rd_data == '0))
		else $error("unmapped read not zero");

	// lamp test, dark loop lamp and state sanity
	AST_LAMP_TEST: assert property (@(posedge clk) disable iff (!rst_b)
		q.ctrl.lamp_test
		|=> (leds == '1))
		else $error("lamp test did not light every lamp");
	AST_LOOP_DARK: assert property (@(posedge clk) disable iff (!rst_b) // [R8] [R9]
		(!q.ctrl.lamp_test && !core.local_tx_loop && !core.local_rx_loop && !core.remote_loop)
		|=> !leds.loop)
		else $error("loop lamp lit with no loopback");
	AST_HEALTH_ONEHOT: assert property (@(posedge clk) disable iff (!rst_b) // [R1] [R2] [R3]
		1'b1
		|-> $onehot(q.health))
		else $error("health state not one-hot");
	AST_DEAD_STATE: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
		core.failed
		|=> (q.health == HS_DEAD))
		else $error("failed system not in dead state");
	AST_FLASH_RANGE: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
		1'b1
		|-> (q.flash_cnt <= FLASH_CNT_W'(FLASH_HALF_CYCLES - 1)))
		else $error("flash divider out of range");

	// main scenarios
	COV_LAMP_TEST: cover property (@(posedge clk) disable iff (!rst_b)
		q.ctrl.lamp_test ##1 (leds == '1));
	COV_REMOTE_FLASH: cover property (@(posedge clk) disable iff (!rst_b)
		core.remote_loop && !core.local_tx_loop && !core.local_rx_loop && $rose(leds.loop));
	COV_CARD_INSERT: cover property (@(posedge clk) disable iff (!rst_b)
		$rose(reprogram_req[0]) ##[1:20] !reprogram_req[0]);
	COV_FAULT_IRQ: cover property (@(posedge clk) disable iff (!rst_b)
		$rose(core.fault) ##[1:3] irq);
	COV_GOOD: cover property (@(posedge clk) disable iff (!rst_b)
		leds.yellow ##1 leds.green);

endmodule : front_panel

// ===== verification/comp_line_model.sv
// composite port line model: clocks and data leads seen by the panel logic
// assumes en changes just after a rising clk edge
`timescale 1ns/1ps
module comp_line_model #(
	parameter int HALF = 3
) (
	input  wire logic            clk,
	input  wire logic [3:0]      en,
	output front_panel_pkg::comp_s comp
);
	import front_panel_pkg::*;
	int cnt = 0;
	initial comp = '0;
	// enabled lines toggle, idle lines hold their last mark or space level
	always @(posedge clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1)
			comp <= comp ^ en;
	end
endmodule : comp_line_model

// ===== verification/front_panel_tb.sv
// self-checking bench for the front-panel indicator logic
// assumes short flash and activity windows set by parameters
`timescale 1ns/1ps
module front_panel_tb;
	import front_panel_pkg::*;
	localparam int FH = 8;
	localparam int AW = 16;
	logic              clk;
	logic              rst_b;
	core_s             core;
	comp_s             comp;
	logic [CARDS-1:0]  card_present;
	logic [CARDS-1:0]  reprogram_done;
	reg_req_s          bus;
	led_s              leds;
	logic [CARDS-1:0]  reprogram_req;
	logic              irq;
	logic [DATA_W-1:0] rd_data;
	logic [3:0]        line_en;
	logic [31:0]       d;
	int                num_errors = 0;
	int                n_compared = 0;
	int                cycles = 0;
	int                n;

	front_panel #(.FLASH_HALF_CYCLES(FH), .ACT_WINDOW_CYCLES(AW)) i_front_panel (
		.clk(clk), .rst_b(rst_b), .core(core), .comp(comp), .card_present(card_present),
		.reprogram_done(reprogram_done), .bus(bus), .leds(leds), .reprogram_req(reprogram_req),
		.irq(irq), .rd_data(rd_data));
	comp_line_model #(.HALF(3)) i_comp_line_model (.clk(clk), .en(line_en), .comp(comp));

	// clock and cycle ceiling
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask : tick

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_leds(input logic [6:0] exp);
		#1;
		chk({25'h0, leds}, {25'h0, exp});
	endtask : chk_leds

	task automatic chk_irq(input logic exp);
		#1;
		chk({31'h0, irq}, {31'h0, exp});
	endtask : chk_irq

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		bus <= '{addr: a, wr_data: v, wr_en: 1'b1, rd_en: 1'b0};
		@(posedge clk);
		bus.wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		bus <= '{addr: a, wr_data: '0, wr_en: 1'b0, rd_en: 1'b1};
		@(posedge clk);
		bus.rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask : rd

	// length of the current loop lamp level, in cycles
	task automatic run_len(output int k);
		logic lvl;
		lvl = leds.loop;
		k = 0;
		while (leds.loop === lvl && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask : run_len

	// main sequence
	initial begin
		rst_b = 1'b0;
		core = '{pending: 1'b1, default: 1'b0};
		bus = '0;
		card_present = '0;
		reprogram_done = '0;
		line_en = '0;
		tick(12);
		rst_b <= 1'b1;
		chk_leds(7'h00);
		tick(2);
		chk_leds(7'h02);
		rd(OFF_IRQ_MASK);
		chk(d, 32'h0);
		rd(OFF_CONTROL);
		chk(d, 32'h0);
		tick(1);
		core.pending <= 1'b0;
		tick(2);
		chk_leds(7'h01);
		rd(8'h10);
		chk(d, 32'h0);
		wr(OFF_INDICATOR, 32'hffff_ffff);
		rd(OFF_INDICATOR);
		chk(d & 32'hffff_ff7f, 32'h0000_2001);
		// lamp test on and off
		wr(OFF_CONTROL, 32'h1);
		tick(1);
		chk_leds(7'h7f);
		wr(OFF_CONTROL, 32'h0);
		tick(1);
		chk_leds(7'h01);
		// fault raises a masked then unmasked interrupt
		tick(1);
		core.fault <= 1'b1;
		tick(2);
		chk_leds(7'h02);
		rd(OFF_IRQ_STATUS);
		chk(d, 32'h1);
		chk_irq(1'b0);
		wr(OFF_IRQ_MASK, 32'h1);
		tick(1);
		chk_irq(1'b1);
		wr(OFF_IRQ_STATUS, 32'h1);
		tick(1);
		chk_irq(1'b0);
		tick(1);
		core.failed <= 1'b1;
		tick(2);
		chk_leds(7'h00);
		rd(OFF_INDICATOR);
		chk(d & 32'hffff_ff7f, 32'h0000_8000);
		tick(1);
		core.failed <= 1'b0;
		core.fault <= 1'b0;
		core.framing_locked <= 1'b1;
		tick(2);
		chk_leds(7'h05);
		core.framing_locked <= 1'b0;
		tick(2);
		chk_leds(7'h01);
		rd(OFF_IRQ_STATUS);
		chk(d, 32'h2);
		wr(OFF_IRQ_MASK, 32'h2);
		tick(1);
		chk_irq(1'b1);
		wr(OFF_IRQ_STATUS, 32'h2);
		tick(1);
		chk_irq(1'b0);
		// line activity: clocks, then each data lead
		tick(1);
		line_en <= 4'b1100;
		tick(3 * AW);
		chk_leds(7'h09);
		tick(1);
		line_en <= 4'b1000;
		tick(AW + 8);
		chk_leds(7'h01);
		rd(OFF_IRQ_STATUS);
		chk(d, 32'h4);
		wr(OFF_IRQ_STATUS, 32'h4);
		tick(1);
		line_en <= 4'b0010;
		tick(10);
		chk_leds(7'h11);
		tick(1);
		line_en <= 4'b0001;
		tick(AW + 8);
		chk_leds(7'h21);
		tick(1);
		line_en <= 4'b0000;
		tick(AW + 8);
		chk_leds(7'h01);
		// remote loop flashes, local loop stays on
		tick(1);
		core.remote_loop <= 1'b1;
		tick(2);
		#1;
		run_len(n);
		run_len(n);
		chk(n, FH);
		run_len(n);
		chk(n, FH);
		for (int i = 0; i < 2; i++) begin
			tick(1);
			core.local_tx_loop <= (i == 0);
			core.local_rx_loop <= (i == 1);
			tick(2);
			repeat (2 * FH) begin
				tick(1);
				chk_leds(7'h41);
			end
		end
		tick(1);
		core.local_rx_loop <= 1'b0;
		core.remote_loop <= 1'b0;
		// hot insert, done, and removal
		card_present[2] <= 1'b1;
		tick(2);
		#1;
		chk({28'h0, reprogram_req}, 32'h4);
		chk_leds(7'h01);
		rd(OFF_IRQ_STATUS);
		chk(d, 32'h8);
		wr(OFF_IRQ_MASK, 32'h8);
		tick(1);
		chk_irq(1'b1);
		tick(1);
		reprogram_done[2] <= 1'b1;
		tick(1);
		reprogram_done[2] <= 1'b0;
		tick(1);
		#1;
		chk({28'h0, reprogram_req}, 32'h0);
		tick(1);
		card_present[1] <= 1'b1;
		tick(2);
		#1;
		chk({28'h0, reprogram_req}, 32'h2);
		tick(1);
		card_present[1] <= 1'b0;
		tick(2);
		#1;
		chk({28'h0, reprogram_req}, 32'h0);
		end_of_test();
	end
endmodule : front_panel_tb
